// [core/spi_regs_defines.vh]
// Constants for the serial peripheral register block
`ifndef SPI_REGS_DEFINES_VH
`define SPI_REGS_DEFINES_VH
// Register indices (byte address is four times the index)
`define IDX_DATA_IO        8'h21
`define IDX_CONTROL        8'h22
`define IDX_CTRL_STATUS    8'h23
`define IDX_IRQ_STATUS     8'h24
`define IDX_IRQ_MASK       8'h25
// Control register fields
`define CR_IRQ_EN          7
`define CR_PORT_EN         6
`define CR_DIV_EN          5
`define CR_MASTER          4
`define CR_CPOL            3
`define CR_CPHA            2
`define CR_RATE_HI         1
`define CR_RATE_LO         0
// Control/status fields
`define SR_DONE            7
`define SR_COLL            6
`define SR_OVR             5
`define SR_MODE_FAULT_FLAG            4
`define SR_RSVD            3
`define SR_OUT_DIS         2
`define SR_SOFT_SEL        1
`define SR_SEL_LVL         0
// Event status bits
`define EV_DONE            0
`define EV_MODE_FAULT_FLAG            1
`define EV_OVR             2
`define EV_COLL            3
`define EV_W               4
// Reset values
`define CR_RESET           8'h00
`define SR_RESET           8'h00
`define BYTE_ZERO          8'h00
`define BIT_COUNT_LAST     3'h7
`define DIV_W              7
`endif

// [core/sync2.v]
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sync2 (
  input  wire clk,   // Block clock
  input  wire rst_n, // Asynchronous reset, active low
  input  wire d,     // Asynchronous input
  output wire q      // Synchronised level
);
  reg s1_r;
  reg s2_r;
  // First stage read only by second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end
  assign q = s2_r;
endmodule // sync2
`default_nettype wire

// [core/sclk_gen.v]
// Master serial clock divider, rate from divider and rate bits
`timescale 1ns/1ns
`default_nettype none
module sclk_gen (
  input  wire       clk,     // Block clock
  input  wire       rst_n,   // Asynchronous reset, active low
  input  wire       run,     // Divider running
  input  wire [2:0] rate,    // {div_en, rate_hi, rate_lo}
  output reg        tick     // One-cycle pulse per half serial period
);
  reg  [6:0] cnt_r;
  reg  [6:0] half;
  // Half period in clocks: f/4..f/128
  always @* begin
    case (rate)
      3'h4: half = 7'h01;
      3'h0: half = 7'h03;
      3'h1: half = 7'h07;
      3'h6: half = 7'h0f;
      3'h2: half = 7'h1f;
      3'h3: half = 7'h3f;
      default: half = 7'h3f;
    endcase
  end
  // Count up to each half-period tick
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 7'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_r <= 7'h00;
      tick  <= 1'b0;
    end else if (cnt_r == half) begin
      cnt_r <= 7'h00;
      tick  <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      tick  <= 1'b0;
    end
  end
endmodule // sclk_gen
`default_nettype wire

// [core/spi_regs.v]
// Serial peripheral interface: APB registers, select management, shifter
// Overview of operation
// (RL1) Master mode select low sets mode fault
// (RL2) Interrupt enable raises interrupt on fault
// (RL3) Fault clears: control access then write
// (RL4) Software writes zero to reserved bit
// (RL5) Output disable releases serial data output
// (RL6) Soft manage bit picks internal select
// (RL7) Internal level zero selects, one deselects
// (RL8) Master data write starts byte transfer
// (RL9) Last serial cycle copies byte to buffer
// (RL10) Data read returns buffer, not shifter
// (RL11) Data writes ignored while done, unread status
// (RL12) Accepted write loads shifter directly
// (RL13) Registers at 21h, 22h, 23h; reset values
// (RL14) Mode fault clears port and master bits
// (RL15) Done flag set; cleared by status-data sequence
// (RL16) Reserved status bit reads zero
`timescale 1ns/1ns
`default_nettype none
`include "spi_regs_defines.vh"
module spi_regs (
  input  wire        CLK,        // Clock, 20 MHz
  input  wire        RST_N,      // Asynchronous reset, active low
  input  wire        PSEL,       // APB select
  input  wire        PENABLE,    // APB access phase
  input  wire        PWRITE,     // APB direction
  input  wire [11:0] PADDR,      // APB byte address
  input  wire [31:0] PWDATA,     // APB write data
  output reg  [31:0] PRDATA,     // APB read data
  output reg         PREADY,     // APB ready
  output reg         PSLVERR,    // APB error, unmapped address
  output reg         IRQ,        // Level interrupt
  input  wire        SCK_I,      // Serial clock in
  output reg         SCK_O,      // Serial clock out
  output reg         SCK_OE_N,   // Serial clock enable, low drives
  input  wire        MOSI_I,     // Master-out line in
  output reg         MOSI_O,     // Master-out line out
  output reg         MOSI_OE_N,  // Master-out enable, low drives
  input  wire        MISO_I,     // Master-in line in
  output reg         MISO_O,     // Master-in line out
  output reg         MISO_OE_N,  // Master-in enable, low drives
  input  wire        SS_N        // Slave select pin, active low
);
  reg  [7:0] ctrl_r;
  reg        done_r, coll_r, ovr_r, mode_fault_flag_r;
  reg  [2:0] selcfg_r;    // out_dis, soft_sel, sel_lvl
  reg  [7:0] shift_r;
  reg  [7:0] rxbuf_r;
  reg  [2:0] bitcnt_r;
  reg        busy_r;
  reg        phase_r;     // Master: 0 before leading edge, 1 before trailing
  reg        sck_prev_r;
  reg        sr_seen_r;   // Status read with done or collision set
  reg        cr_seen_r;   // Control accessed while fault set
  reg  [`EV_W-1:0] ev_r;
  reg  [`EV_W-1:0] mask_r;
  wire       sck_s, mosi_s, miso_s, ss_s;
  wire       tick;
  // Pin synchronisers, one per input
  wire [3:0] pins_a = {SCK_I, MOSI_I, MISO_I, SS_N};
  wire [3:0] pins_s;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      sync2 u_sync (.clk(CLK), .rst_n(RST_N), .d(pins_a[gi]), .q(pins_s[gi]));
    end
  endgenerate
  assign sck_s  = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign ss_s   = pins_s[0];
  // Effective select level
  wire sel_n    = selcfg_r[1] ? selcfg_r[0] : ss_s;        // see (RL6) see (RL7)
  wire master   = ctrl_r[`CR_MASTER];
  wire enabled  = ctrl_r[`CR_PORT_EN];
  wire fault    = master & enabled & ~sel_n;                 // see (RL1)
  // APB decode
  wire        acc     = PSEL & PENABLE & PREADY;
  wire [9:0]  idx     = PADDR[11:2];
  wire        a_data  = (idx == {2'h0, `IDX_DATA_IO});
  wire        a_ctrl  = (idx == {2'h0, `IDX_CONTROL});
  wire        a_sr    = (idx == {2'h0, `IDX_CTRL_STATUS});
  wire        a_ist   = (idx == {2'h0, `IDX_IRQ_STATUS});
  wire        a_imsk  = (idx == {2'h0, `IDX_IRQ_MASK});
  wire        mapped  = a_data | a_ctrl | a_sr | a_ist | a_imsk;
  wire        wr      = acc & PWRITE;
  wire        rd      = acc & ~PWRITE;
  wire        data_ok = wr & a_data & ~(done_r & ~sr_seen_r);    // see (RL11)
  wire        start   = data_ok & master & enabled & ~busy_r;     // see (RL8)
  wire        collide = wr & a_data & busy_r;
  // Serial edges seen on the sampled clock, or made by the divider
  wire cpol    = ctrl_r[`CR_CPOL];
  wire cpha    = ctrl_r[`CR_CPHA];
  wire s_rise  = sck_s & ~sck_prev_r;
  wire s_fall  = ~sck_s & sck_prev_r;
  wire s_lead  = cpol ? s_fall : s_rise;
  wire s_trail = cpol ? s_rise : s_fall;
  wire m_lead  = busy_r & tick & ~phase_r;
  wire m_trail = busy_r & tick & phase_r;
  wire slave_on = ~master & enabled & ~sel_n;
  wire lead    = master ? m_lead : (slave_on & s_lead);
  wire trail   = master ? m_trail : (slave_on & s_trail);
  // Master samples and shifts on its trailing tick: the synchronised return
  // bit has settled by then, and MOSI moves as SCK goes back to idle
  wire samp_e  = master ? trail : (cpha ? trail : lead);
  wire din     = master ? miso_s : mosi_s;
  wire last    = samp_e & (bitcnt_r == `BIT_COUNT_LAST);
  wire byte_end = last;

  sclk_gen u_sclk (
    .clk   (CLK),
    .rst_n (RST_N),
    .run   (busy_r & master),
    .rate  ({ctrl_r[`CR_DIV_EN], ctrl_r[`CR_RATE_HI], ctrl_r[`CR_RATE_LO]}),
    .tick  (tick)
  );

  // Control register and hardware clear on fault
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= `CR_RESET;                                       // see (RL13)
    end else if (fault) begin
      ctrl_r[`CR_PORT_EN] <= 1'b0;                               // see (RL14)
      ctrl_r[`CR_MASTER]  <= 1'b0;                               // see (RL14)
    end else if (wr & a_ctrl) begin
      ctrl_r <= PWDATA[7:0];
    end
  end

  // Software-owned select/output bits; reserved bit never stored
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      selcfg_r <= 3'h0;
    end else if (wr & a_sr) begin
      selcfg_r <= PWDATA[`SR_OUT_DIS:`SR_SEL_LVL];              // see (RL16)
    end
  end

  // Fault flag with its clear sequence; set wins
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_fault_flag_r    <= 1'b0;
      cr_seen_r <= 1'b0;
    end else begin
      if (fault) begin
        mode_fault_flag_r <= 1'b1;                                          // see (RL1)
      end else if (wr & a_ctrl & cr_seen_r) begin
        mode_fault_flag_r <= 1'b0;                                          // see (RL3)
      end
      if (acc & a_ctrl & ~(wr & cr_seen_r)) begin
        cr_seen_r <= mode_fault_flag_r;                                     // see (RL3)
      end else if (wr & a_ctrl) begin
        cr_seen_r <= 1'b0;
      end
    end
  end

  // Done, overrun and collision flags
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_r    <= 1'b0;
      ovr_r     <= 1'b0;
      coll_r    <= 1'b0;
      sr_seen_r <= 1'b0;
    end else begin
      if (rd & a_sr) begin
        sr_seen_r <= done_r | coll_r;
      end else if (acc & a_data) begin
        sr_seen_r <= 1'b0;
      end
      if (byte_end) begin
        done_r <= 1'b1;                                          // see (RL15)
      end else if (acc & a_data & sr_seen_r) begin
        done_r <= 1'b0;                                          // see (RL15)
      end
      if (byte_end & done_r) begin
        ovr_r <= 1'b1;
      end else if (rd & a_sr) begin
        ovr_r <= 1'b0;
      end
      if (collide) begin
        coll_r <= 1'b1;
      end else if (acc & a_data & sr_seen_r) begin
        coll_r <= 1'b0;
      end
    end
  end

  // Shifter, bit counter and receive buffer
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_r    <= `BYTE_ZERO;
      rxbuf_r    <= `BYTE_ZERO;
      bitcnt_r   <= 3'h0;
      busy_r     <= 1'b0;
      phase_r    <= 1'b0;
      sck_prev_r <= 1'b1;
    end else begin
      sck_prev_r <= sck_s;
      if (data_ok & ~busy_r) begin
        shift_r  <= PWDATA[7:0];                                 // see (RL12)
        bitcnt_r <= 3'h0;
      end else begin
        if (samp_e) begin
          shift_r  <= {shift_r[6:0], din};
          bitcnt_r <= bitcnt_r + 3'h1;
        end
        if (last) begin
          rxbuf_r <= {shift_r[6:0], din};                        // see (RL9)
        end
      end
      if (start) begin
        phase_r <= 1'b0;
      end else if (tick & busy_r) begin
        phase_r <= ~phase_r;
      end
      // Busy from start, or from a slave's first leading edge, to the eighth sample
      if (start) begin
        busy_r <= 1'b1;
      end else if (!enabled | byte_end) begin
        busy_r <= 1'b0;
      end else if (~master & slave_on & s_lead) begin
        busy_r <= 1'b1;
      end
    end
  end

  // Sticky events, cleared by writing one; set wins
  wire [`EV_W-1:0] ev_set = {collide, byte_end & done_r, fault, byte_end};
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ev_r   <= {`EV_W{1'b0}};
      mask_r <= {`EV_W{1'b0}};
    end else begin
      ev_r <= ev_set | (ev_r & ~((wr & a_ist) ? PWDATA[`EV_W-1:0] : {`EV_W{1'b0}}));
      if (wr & a_imsk) begin
        mask_r <= PWDATA[`EV_W-1:0];
      end
    end
  end

  // Read mux
  reg [7:0] rdv;
  always @* begin
    rdv = `BYTE_ZERO;
    if (a_data) rdv = rxbuf_r;                                   // see (RL10)
    if (a_ctrl) rdv = ctrl_r;
    if (a_sr)   rdv = {done_r, coll_r, ovr_r, mode_fault_flag_r, 1'b0, selcfg_r}; // see (RL16)
    if (a_ist)  rdv = {4'h0, ev_r};
    if (a_imsk) rdv = {4'h0, mask_r};
  end

  // APB answer: one wait state, ready on second access cycle
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & ~mapped;
      if (PSEL & PENABLE & ~PREADY & ~PWRITE) begin
        PRDATA <= {24'h000000, rdv};
      end
    end
  end

  // Interrupt and pin drivers, all registered
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ       <= 1'b0;
      SCK_O     <= 1'b0;
      SCK_OE_N  <= 1'b1;
      MOSI_O    <= 1'b0;
      MOSI_OE_N <= 1'b1;
      MISO_O    <= 1'b0;
      MISO_OE_N <= 1'b1;
    end else begin
      IRQ <= (ctrl_r[`CR_IRQ_EN] & (done_r | mode_fault_flag_r | ovr_r))   // see (RL2)
             | (|(ev_r & mask_r));
      SCK_O     <= cpol ^ (busy_r & master & phase_r);
      SCK_OE_N  <= ~(enabled & master);
      MOSI_O    <= shift_r[7];
      MOSI_OE_N <= ~(enabled & master & ~selcfg_r[2]);          // see (RL5)
      MISO_O    <= shift_r[7];
      MISO_OE_N <= ~(slave_on & ~selcfg_r[2]);                  // see (RL5)
    end
  end
endmodule // spi_regs
`default_nettype wire

// [verification/spi_regs_monitor.sv]
// Port checker for the serial register block
`timescale 1ns/1ns
`default_nettype none
module spi_regs_monitor (
  input wire logic        CLK,       // Clock
  input wire logic        RST_N,     // Reset, active low
  input wire logic        PSEL,      // APB select
  input wire logic        PENABLE,   // APB access phase
  input wire logic        PWRITE,    // APB direction
  input wire logic [11:0] PADDR,     // APB address
  input wire logic [31:0] PRDATA,    // APB read data
  input wire logic        PREADY,    // APB ready
  input wire logic        PSLVERR,   // APB error
  input wire logic        SCK_O,     // Serial clock out
  input wire logic        SCK_OE_N,  // Serial clock enable
  input wire logic        MOSI_O,    // Master-out data
  input wire logic        MOSI_OE_N, // Master-out enable
  input wire logic        MISO_OE_N  // Master-in enable
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // Access phase still waiting, and no access at all
  sequence s_wait;
    PSEL && PENABLE && !PREADY;
  endsequence
  sequence s_idle;
    !(PSEL && PENABLE);
  endsequence
  a_ready_next: assert property (s_wait |=> PREADY)
    else $error("ready late");
  a_ready_cause: assert property (s_idle |=> !PREADY)
    else $error("ready without access");
  a_ready_once: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  a_err_map: assert property (PREADY |-> PSLVERR ==
    !(PADDR inside {12'h084, 12'h088, 12'h08c, 12'h090, 12'h094}))
    else $error("error flag wrong");
  a_rd_upper: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
    else $error("read upper bits set");
  a_out_needs_port: assert property (!MOSI_OE_N |-> !SCK_OE_N)
    else $error("data out without port");
  a_master_miso: assert property (!SCK_OE_N |-> MISO_OE_N)
    else $error("master drives input line");
  a_data_setup: assert property ($changed(MOSI_O) && !MOSI_OE_N |-> !SCK_O)
    else $error("data moved with clock high");
endmodule // spi_regs_monitor
`default_nettype wire

// [verification/spi_slave_model.sv]
// Behavioural serial slave on the far side of the link
`timescale 1ns/1ns
`default_nettype none
module spi_slave_model (
  input  wire logic       sck,     // Serial clock from the master
  input  wire logic       mosi,    // Data from the master
  input  wire logic [7:0] tx_byte, // Next byte to return
  output var  logic       miso,    // Data to the master
  output var  logic [7:0] rx_byte, // Last byte received
  output var  int         n_rx     // Bytes received
);
  logic [7:0] sh = 8'h00;
  int         bits = 0;
  initial begin
    n_rx = 0;
    rx_byte = 8'h00;
  end
  // Sample on the rising edge, first bit is the top one
  always @(posedge sck) begin
    sh = {sh[6:0], mosi};
    bits = (bits + 1) % 8;
    if (bits == 0) begin
      rx_byte = sh;
      n_rx++;
    end
  end
  // Next bit goes out after each falling edge
  always @(negedge sck or tx_byte) begin
    miso = tx_byte[7 - bits];
  end
endmodule // spi_slave_model
`default_nettype wire

// [verification/tb_top.sv]
// Self-checking bench for the serial register block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk, rst_n, rerr, flt, pready, pslverr, irq, sck_o, sck_oe_n;
  logic        mosi_o, mosi_oe_n, miso_o, miso_oe_n, miso_w;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ss_n = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [7:0]  slv_byte = 8'h00, slv_rx, tx, csr;
  wire         sck_w  = sck_oe_n ? 1'b0 : sck_o;   // Pull-down when released
  wire         mosi_w = mosi_oe_n ? 1'b1 : mosi_o; // Pull-up when released
  int          n_mismatch = 0, n_tests = 0, cyc = 0, seed = 48, n_rx, n0, i, k;
  int          exp_q[$];
  spi_regs spi_regs_inst (
    .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq), .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_N(sck_oe_n), .MOSI_I(mosi_w),
    .MOSI_O(mosi_o), .MOSI_OE_N(mosi_oe_n), .MISO_I(miso_w), .MISO_O(miso_o),
    .MISO_OE_N(miso_oe_n), .SS_N(ss_n));
  spi_slave_model spi_slave_model_inst (
    .sck(sck_w), .mosi(mosi_w), .tx_byte(slv_byte), .miso(miso_w), .rx_byte(slv_rx),
    .n_rx(n_rx));
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, entered just after an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    rerr = pslverr;
    if (n >= 20) n_mismatch++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // Bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000) n_mismatch++;
  endtask
  // Verdict and end of run
  task automatic close_out();
    if (n_mismatch == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  // Reset, then the scenarios in turn
  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(0, 12'h08c, 0);
    chk(rdata, 32'h0);
    apb(0, 12'h088, 0);
    chk(rdata & 32'hf0, 32'h0);
    apb(0, 12'h098, 0);
    chk(rerr, 1'b1);
    // Control bits read back, flags ignore writes, reserved bit always written as zero
    for (i = 0; i < 4; i++) begin
      csr = $random(seed);
      apb(1, 12'h08c, {24'h0, csr & 8'hf7});
      apb(0, 12'h08c, 0);
      chk(rdata, {29'h0, csr[2:0]});
    end
    // Fault by pin, fault by soft select, pin ignored under soft select
    for (k = 0; k < 3; k++) begin
      flt = (k != 2);
      csr = (k == 0) ? 8'h00 : (k == 1) ? 8'h02 : 8'h07;
      apb(1, 12'h08c, {24'h0, csr});
      ss_n <= (k == 1);
      apb(1, 12'h088, 32'hd0);
      repeat (10) @(posedge clk);
      chk(irq, flt);
      chk(mosi_oe_n, 1'b1);
      apb(0, 12'h08c, 0);
      chk(rdata, (flt ? 32'h10 : 32'h0) | csr);
      apb(0, 12'h088, 0);
      chk(rdata, flt ? 32'h80 : 32'hd0);
      apb(1, 12'h088, 0);
      ss_n <= 1'b1;
      apb(0, 12'h08c, 0);
      chk(rdata, {24'h0, csr});
      apb(1, 12'h08c, 0);
      apb(0, 12'h090, 0);
      chk(rdata, flt ? 32'h2 : 32'h0);
      apb(1, 12'h090, 32'hf);
    end
    // Byte transfers, interrupt by enable bit or by event mask
    for (i = 0; i < 6; i++) begin
      tx = $random(seed);
      n0 = $random(seed) & 255;
      slv_byte <= n0[7:0];
      exp_q.push_back(n0);
      apb(1, 12'h094, {31'h0, i[0]});
      apb(1, 12'h088, i[0] ? 32'h50 : 32'hd0);
      apb(1, 12'h084, {24'h0, tx});
      wait_irq();
      chk(mosi_oe_n, 1'b0);
      n0 = n_rx;
      apb(1, 12'h084, {24'h0, ~tx});
      repeat (80) @(posedge clk);
      chk(n_rx, n0);
      chk(slv_rx, tx);
      apb(0, 12'h08c, 0);
      chk(rdata, 32'h80);
      apb(0, 12'h084, 0);
      chk(rdata, exp_q.pop_front());
      apb(0, 12'h090, 0);
      chk(rdata, 32'h1);
      apb(1, 12'h090, 32'h1);
      apb(0, 12'h08c, 0);
      chk(rdata, 32'h0);
      chk(irq, 1'b0);
    end
    close_out();
  end
endmodule // tb_top
bind spi_regs spi_regs_monitor spi_regs_monitor_inst (
  .CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SCK_O(SCK_O),
  .SCK_OE_N(SCK_OE_N), .MOSI_O(MOSI_O), .MOSI_OE_N(MOSI_OE_N), .MISO_OE_N(MISO_OE_N));
`default_nettype wire
